/* File: design/dcc_pkg.sv */
// constants and types of the dma channel control block
// Operation
// - busy reads 1 while channel active or enabled
// - write enable bit turns channel on/off
// - disable waits for transaction end, then suspends
// - chain direction picks higher or lower neighbour
// - direction ignored unless chaining is allowed
// - chain allow gates neighbour completion enabling
// - off channel accepts events only when allowed
// - auto re-enable keeps channel on after block
// - event flag set when channel event detected
// - two-bit priority, three highest, zero lowest
// - unimplemented control bits read zero
package dcc_pkg;
   localparam int unsigned NCH = 4;
   localparam int unsigned CHW = 2;
   // byte addresses
   localparam logic [7:0] ADDR_CTRL0 = 8'h00; // channel n at ADDR_CTRL0 + 4n
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_GRANT = 8'h18;
   // control register fields
   localparam int unsigned BIT_BUSY = 15;
   localparam int unsigned BIT_DIR = 8;
   localparam int unsigned BIT_ON = 7;
   localparam int unsigned BIT_AED = 6;
   localparam int unsigned BIT_CHN = 5;
   localparam int unsigned BIT_AEN = 4;
   localparam int unsigned BIT_EDET = 2;
   localparam int unsigned BIT_PRI = 0;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_01F3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // status bits per channel: block done at n, suspended at NCH+n
   localparam int unsigned STAT_W = 2 * NCH;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      DCC_IDLE = 2'b00,
      DCC_RUN = 2'b01,
      DCC_DRAIN = 2'b11
   } dcc_state_t;
endpackage

/* File: design/dcc_chan_if.sv */
// per-channel control and status bundle
`timescale 1ns/1ps
interface dcc_chan_if;
   logic on;
   logic aed;
   logic aen;
   logic start_ev;
   logic abort_ev;
   logic xfer_busy;
   logic block_done;
   logic chain_en;
   logic busy;
   logic clr_on;
   logic edet;
   logic suspended;
   logic done_pulse;
   modport ctl (input on, aed, aen, start_ev, abort_ev, xfer_busy, block_done, chain_en,
      output busy, clr_on, edet, suspended, done_pulse);
   modport top (output on, aed, aen, start_ev, abort_ev, xfer_busy, block_done, chain_en,
      input busy, clr_on, edet, suspended, done_pulse);
endinterface

/* File: design/dcc_chan_fsm.sv */
// run state of one dma channel
`timescale 1ns/1ps
module dcc_chan_fsm (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic edet_clr,
   dcc_chan_if.ctl ch
);
   dcc_pkg::dcc_state_t state_reg, state_next;
   logic edet_reg, edet_next;
   logic ev_ok;

   // next state
   always_comb begin
      ev_ok = ch.on | ch.aed;
      state_next = state_reg;
      edet_next = edet_reg & ~edet_clr;
      if (ev_ok && (ch.start_ev || ch.abort_ev)) begin
         edet_next = 1'b1;
      end
      unique case (state_reg)
         dcc_pkg::DCC_IDLE: begin
            if (ch.on || ch.chain_en) begin
               state_next = dcc_pkg::DCC_RUN;
            end
         end
         dcc_pkg::DCC_RUN: begin
            if (!ch.on || (ev_ok && ch.abort_ev)) begin
               state_next = ch.xfer_busy ? dcc_pkg::DCC_DRAIN : dcc_pkg::DCC_IDLE;
            end
         end
         dcc_pkg::DCC_DRAIN: begin
            if (!ch.xfer_busy) begin
               state_next = ch.on ? dcc_pkg::DCC_RUN : dcc_pkg::DCC_IDLE;
            end
         end
         default: state_next = dcc_pkg::DCC_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= dcc_pkg::DCC_IDLE;
         edet_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         edet_reg <= edet_next;
      end
   end

   assign ch.busy = ch.on | (state_reg != dcc_pkg::DCC_IDLE);
   assign ch.clr_on = ch.block_done & ch.on & ~ch.aen;
   assign ch.edet = edet_reg;
   assign ch.suspended = (state_reg == dcc_pkg::DCC_DRAIN) && !ch.xfer_busy && !ch.on;
   assign ch.done_pulse = ch.block_done & ch.on;
endmodule // dcc_chan_fsm

/* File: design/dcc_top.sv */
// dma channel control registers, chaining and priority grant
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module dcc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] start_ev,
   input wire logic [3:0] abort_ev,
   input wire logic [3:0] xfer_busy,
   input wire logic [3:0] block_done,
   input wire logic [3:0] req,
   output logic [3:0] chan_on,
   output logic grant_valid,
   output logic [1:0] grant_chan,
   output logic irq
);
   localparam int unsigned N = dcc_pkg::NCH;

   // control fields per channel
   logic [N-1:0] on_reg, on_next;
   logic [N-1:0] aed_reg, aed_next;
   logic [N-1:0] chn_reg, chn_next;
   logic [N-1:0] aen_reg, aen_next;
   logic [N-1:0] dir_reg, dir_next;
   logic [1:0] pri_reg [N], pri_next [N];
   logic [N-1:0] busy_w, clr_on_w, edet_w, susp_w, done_w, chain_w;
   logic [N-1:0] edet_clr;
   // interrupt state
   logic [dcc_pkg::STAT_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
   // bus state
   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic grant_valid_reg, grant_valid_next;
   logic [1:0] grant_chan_reg, grant_chan_next;
   logic irq_reg, irq_next;
   logic wr_go, rd_go;

   // decode a byte address to a channel control index, or none
   function automatic logic [2:0] ctrl_index(input logic [7:0] a);
      ctrl_index = 3'h4;
      if (a[7:4] == 4'h0 && a[1:0] == 2'h0) begin
         ctrl_index = {1'b0, a[3:2]};
      end
   endfunction

   // assemble a channel control word; reserved bits read zero
   function automatic logic [31:0] ctrl_word(input int unsigned c);
      ctrl_word = dcc_pkg::CTRL_RESET;
      ctrl_word[dcc_pkg::BIT_BUSY] = busy_w[c];
      ctrl_word[dcc_pkg::BIT_DIR] = dir_reg[c];
      ctrl_word[dcc_pkg::BIT_ON] = on_reg[c];
      ctrl_word[dcc_pkg::BIT_AED] = aed_reg[c];
      ctrl_word[dcc_pkg::BIT_CHN] = chn_reg[c];
      ctrl_word[dcc_pkg::BIT_AEN] = aen_reg[c];
      ctrl_word[dcc_pkg::BIT_EDET] = edet_w[c];
      ctrl_word[dcc_pkg::BIT_PRI +: 2] = pri_reg[c];
   endfunction

   assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
   assign rd_go = s_axi_arvalid && !rvalid_reg;

   // one channel engine each, plus chaining source select
   generate
      for (genvar g = 0; g < N; g++) begin : g_ch
         dcc_chan_if cif ();
         logic from_low, from_high;
         if (g > 0) begin : g_lo
            assign from_low = done_w[g-1];
         end else begin : g_lo0
            assign from_low = 1'b0;
         end
         if (g < N - 1) begin : g_hi
            assign from_high = done_w[g+1];
         end else begin : g_hi0
            assign from_high = 1'b0;
         end
         // direction only matters with chaining allowed
         assign chain_w[g] = chn_reg[g] & (dir_reg[g] ? from_high : from_low);
         assign cif.on = on_reg[g];
         assign cif.aed = aed_reg[g];
         assign cif.aen = aen_reg[g];
         assign cif.start_ev = start_ev[g];
         assign cif.abort_ev = abort_ev[g];
         assign cif.xfer_busy = xfer_busy[g];
         assign cif.block_done = block_done[g];
         assign cif.chain_en = chain_w[g];
         assign busy_w[g] = cif.busy;
         assign clr_on_w[g] = cif.clr_on;
         assign edet_w[g] = cif.edet;
         assign susp_w[g] = cif.suspended;
         assign done_w[g] = cif.done_pulse;
         dcc_chan_fsm u_fsm (
            .aclk(aclk),
            .aresetn(aresetn),
            .edet_clr(edet_clr[g]),
            .ch(cif.ctl)
         );
      end
   endgenerate

   // register writes, hardware updates and interrupt status
   always_comb begin
      logic [2:0] wi;
      logic [31:0] d;
      wi = ctrl_index(awaddr_reg);
      d = wdata_reg & dcc_pkg::CTRL_WMASK;
      on_next = on_reg;
      aed_next = aed_reg;
      chn_next = chn_reg;
      aen_next = aen_reg;
      dir_next = dir_reg;
      pri_next = pri_reg;
      edet_clr = '0;
      mask_next = mask_reg;
      stat_next = stat_reg;
      if (wr_go && !wi[2] && wstrb_reg[0]) begin
         on_next[wi[1:0]] = d[dcc_pkg::BIT_ON];
         aed_next[wi[1:0]] = d[dcc_pkg::BIT_AED];
         chn_next[wi[1:0]] = d[dcc_pkg::BIT_CHN];
         aen_next[wi[1:0]] = d[dcc_pkg::BIT_AEN];
         pri_next[wi[1:0]] = d[dcc_pkg::BIT_PRI +: 2];
         edet_clr[wi[1:0]] = ~wdata_reg[dcc_pkg::BIT_EDET]; // zero clears
      end
      if (wr_go && !wi[2] && wstrb_reg[1]) begin
         dir_next[wi[1:0]] = d[dcc_pkg::BIT_DIR];
      end
      if (wr_go && awaddr_reg == dcc_pkg::ADDR_STAT) begin
         stat_next = stat_reg & ~wdata_reg[dcc_pkg::STAT_W-1:0];
      end
      if (wr_go && awaddr_reg == dcc_pkg::ADDR_MASK) begin
         mask_next = wdata_reg[dcc_pkg::STAT_W-1:0];
      end
      // hardware events beat software writes
      for (int c = 0; c < N; c++) begin
         if (clr_on_w[c]) begin
            on_next[c] = 1'b0;
         end
         if (chain_w[c]) begin
            on_next[c] = 1'b1;
         end
         stat_next[c] = stat_next[c] | done_w[c];
         stat_next[N+c] = stat_next[N+c] | susp_w[c];
      end
      irq_next = |(stat_next & mask_next);
   end

   // fixed-priority grant among requesting enabled channels
   always_comb begin
      logic [1:0] best;
      best = 2'h0;
      grant_valid_next = 1'b0;
      grant_chan_next = 2'h0;
      for (int c = 0; c < N; c++) begin
         if (req[c] && on_reg[c] && (!grant_valid_next || pri_reg[c] > best)) begin
            grant_valid_next = 1'b1;
            grant_chan_next = c[1:0];
            best = pri_reg[c];
         end
      end
   end

   // axi write and read channels
   always_comb begin
      logic [2:0] ri;
      logic [2:0] wj;
      ri = ctrl_index(s_axi_araddr);
      wj = ctrl_index(awaddr_reg);
      aw_full_next = aw_full_reg;
      w_full_next = w_full_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_awvalid && !aw_full_reg) begin
         aw_full_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
         w_full_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (!wj[2] || awaddr_reg == dcc_pkg::ADDR_STAT ||
            awaddr_reg == dcc_pkg::ADDR_MASK) ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (rd_go) begin
         rvalid_next = 1'b1;
         rresp_next = dcc_pkg::RESP_OKAY;
         rdata_next = 32'h0000_0000;
         if (!ri[2]) begin
            rdata_next = ctrl_word(32'(ri[1:0]));
         end else if (s_axi_araddr == dcc_pkg::ADDR_STAT) begin
            rdata_next[dcc_pkg::STAT_W-1:0] = stat_reg;
         end else if (s_axi_araddr == dcc_pkg::ADDR_MASK) begin
            rdata_next[dcc_pkg::STAT_W-1:0] = mask_reg;
         end else if (s_axi_araddr == dcc_pkg::ADDR_GRANT) begin
            rdata_next[2:0] = {grant_valid_reg, grant_chan_reg};
         end else begin
            rresp_next = dcc_pkg::RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // all registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_reg <= '0;
         aed_reg <= '0;
         chn_reg <= '0;
         aen_reg <= '0;
         dir_reg <= '0;
         for (int c = 0; c < N; c++) begin
            pri_reg[c] <= 2'h0;
         end
         stat_reg <= '0;
         mask_reg <= '0;
         irq_reg <= 1'b0;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
         grant_valid_reg <= 1'b0;
         grant_chan_reg <= 2'h0;
      end else begin
         on_reg <= on_next;
         aed_reg <= aed_next;
         chn_reg <= chn_next;
         aen_reg <= aen_next;
         dir_reg <= dir_next;
         pri_reg <= pri_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         grant_valid_reg <= grant_valid_next;
         grant_chan_reg <= grant_chan_next;
      end
   end

   // outputs straight from flip-flops
   assign s_axi_awready = ~aw_full_reg;
   assign s_axi_wready = ~w_full_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign chan_on = on_reg;
   assign grant_valid = grant_valid_reg;
   assign grant_chan = grant_chan_reg;
   assign irq = irq_reg;
endmodule // dcc_top

/* File: tb/dcc_top_properties.sv */
// port assertions for the dma channel control block
`timescale 1ns/1ps
module dcc_top_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [3:0] block_done,
   input wire logic [3:0] req,
   input wire logic [3:0] chan_on,
   input wire logic grant_valid,
   input wire logic [1:0] grant_chan
);
   logic [7:0] ar_q;
   logic [3:0] req_on_q;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // last read address and request history
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ar_q <= s_axi_araddr;
      end
      req_on_q <= req & chan_on;
   end
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_on_rise_cause: assert property (((chan_on & ~$past(chan_on)) != 4'h0) |->
      (s_axi_bvalid || $past(|block_done))) else $error("channel on without cause");
   a_on_fall_cause: assert property (((~chan_on & $past(chan_on)) != 4'h0) |->
      (s_axi_bvalid || $past(|block_done))) else $error("channel off without cause");
   a_grant_valid: assert property (grant_valid == (|req_on_q))
      else $error("grant valid wrong");
   a_grant_sel: assert property (grant_valid |-> req_on_q[grant_chan])
      else $error("grant to idle channel");
   a_ctrl_zeros: assert property (s_axi_rvalid && ar_q[7:4] == 4'h0 |->
      s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[14:9] == 6'h0 && !s_axi_rdata[3])
      else $error("unused control bits set");
   a_busy_on: assert property (s_axi_rvalid && ar_q[7:4] == 4'h0 && s_axi_rdata[7]
      |-> s_axi_rdata[15]) else $error("busy low while on");
endmodule // dcc_top_properties

bind dcc_top dcc_top_properties u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .block_done(block_done),
   .req(req), .chan_on(chan_on), .grant_valid(grant_valid), .grant_chan(grant_chan));

/* File: tb/dcc_top_tb_top.sv */
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
module dcc_top_tb_top;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, grant_valid, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv, v;
   logic [3:0] wstrb, start_ev, abort_ev, xfer_busy, block_done, req, chan_on;
   logic [1:0] bresp, rresp, rsp, grant_chan;
   logic [31:0] m_ctl [4];
   logic [31:0] cv [5] = '{32'h20, 32'h120, 32'h20, 32'h120, 32'h100};
   int src [5] = '{0, 2, 2, 0, 2};
   int n_errors, n_compared, n, k, i, best;
   dcc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .start_ev(start_ev),
      .abort_ev(abort_ev), .xfer_busy(xfer_busy), .block_done(block_done), .req(req),
      .chan_on(chan_on), .grant_valid(grant_valid), .grant_chan(grant_chan), .irq(irq));
   // clock generation
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic fail_wait;
      n_errors++;
      $display("MISMATCH at %0t: bus wait timed out", $time);
      complete_run();
   endtask
   // bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (i == 50) fail_wait();
      rsp = bresp;
      bready <= 1'b0;
   endtask
   // bus read
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (i == 50) fail_wait();
      rdv = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // control write with model update, edge flag cleared by a zero
   task automatic wc(input int c, input logic [31:0] d);
      wr(dcc_pkg::ADDR_CTRL0 + 8'(4 * c), d);
      m_ctl[c] = (d & dcc_pkg::CTRL_WMASK) | (d[2] ? (m_ctl[c] & 32'h4) : 32'h0);
   endtask
   // control read against model
   task automatic cc(input int c);
      rd(dcc_pkg::ADDR_CTRL0 + 8'(4 * c));
      chk(rdv, m_ctl[c] | (m_ctl[c][7] ? 32'h0000_8000 : 32'h0));
      chk(chan_on, {m_ctl[3][7], m_ctl[2][7], m_ctl[1][7], m_ctl[0][7]});
   endtask
   // one-cycle event pulse: 0 start, 1 abort, 2 block done
   task automatic pulse(input int kind, input logic [3:0] m);
      @(posedge aclk);
      if (kind == 0) start_ev <= m;
      else if (kind == 1) abort_ev <= m;
      else block_done <= m;
      @(posedge aclk);
      start_ev <= 4'h0;
      abort_ev <= 4'h0;
      block_done <= 4'h0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic irqc(input logic e);
      repeat (2) @(posedge aclk);
      chk(irq, e);
   endtask
   // main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb} = {8'h0, 8'h0, 32'h0, 4'hF};
      {start_ev, abort_ev, xfer_busy, block_done, req} = 20'h0;
      aresetn = 1'b0;
      v = $urandom(32'h539b);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (n = 0; n < 4; n++) begin
         m_ctl[n] = 32'h0;
         cc(n);
      end
      wr(8'h1C, 32'hFFFF_FFFF);
      chk(rsp, dcc_pkg::RESP_SLVERR);
      rd(8'h1C);
      chk(rdv, 32'h0);
      chk(rsp, dcc_pkg::RESP_SLVERR);
      for (k = 0; k < 8; k++) begin
         n = $urandom % 4;
         wc(n, $urandom);
         cc(n);
      end
      for (n = 0; n < 4; n++) wc(n, 32'h0);
      wc(2, 32'h0);
      pulse(0, 4'h4);
      cc(2);
      wc(2, 32'h40);
      pulse(1, 4'h4);
      m_ctl[2] |= 32'h4;
      cc(2);
      wc(2, 32'h44);
      cc(2);
      wc(2, 32'h40);
      cc(2);
      wc(1, 32'h80);
      wr(dcc_pkg::ADDR_STAT, 32'hFF);
      xfer_busy <= 4'h2;
      pulse(0, 4'h2);
      wc(1, 32'h0);
      rd(dcc_pkg::ADDR_CTRL0 + 8'h4);
      chk(rdv, 32'h0000_8000);
      chk(chan_on, 4'h0);
      xfer_busy <= 4'h0;
      for (k = 0; k < 20; k++) begin
         rd(dcc_pkg::ADDR_CTRL0 + 8'h4);
         if (rdv[15] === 1'b0) break;
      end
      chk(rdv, 32'h0);
      rd(dcc_pkg::ADDR_STAT);
      chk(rdv, 32'h20);
      wr(dcc_pkg::ADDR_MASK, 32'h20);
      irqc(1'b1);
      wr(dcc_pkg::ADDR_MASK, 32'h0);
      irqc(1'b0);
      wr(dcc_pkg::ADDR_MASK, 32'h20);
      irqc(1'b1);
      wr(dcc_pkg::ADDR_STAT, 32'h20);
      irqc(1'b0);
      rd(dcc_pkg::ADDR_STAT);
      chk(rdv, 32'h0);
      wc(3, 32'h80);
      pulse(2, 4'h8);
      m_ctl[3] = 32'h0;
      cc(3);
      rd(dcc_pkg::ADDR_STAT);
      chk(rdv & 32'h8, 32'h8);
      wc(3, 32'h90);
      pulse(2, 4'h8);
      cc(3);
      wc(3, 32'h0);
      // chaining table: ch1 setup, source channel, enabled only in first two
      for (k = 0; k < 5; k++) begin
         wc(1, cv[k]);
         wc(src[k], 32'h80);
         pulse(2, 4'(1 << src[k]));
         m_ctl[src[k]] = 32'h0;
         if (k < 2) m_ctl[1] |= 32'h80;
         cc(1);
         wc(1, 32'h0);
      end
      for (k = 0; k < 8; k++) begin
         for (n = 0; n < 4; n++) wc(n, $urandom & 32'h83);
         req <= 4'($urandom);
         repeat (3) @(posedge aclk);
         best = -1;
         for (n = 0; n < 4; n++) begin
            if (req[n] && m_ctl[n][7] && (best < 0 || m_ctl[n][1:0] > m_ctl[best][1:0])) best = n;
         end
         chk(grant_valid, best >= 0);
         if (best >= 0) chk(grant_chan, 2'(best));
         rd(dcc_pkg::ADDR_GRANT);
         chk(rdv, (best >= 0) ? 32'(4 + best) : 32'h0);
      end
      // reset in mid-run: controls and outputs back to zero
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(chan_on, 4'h0);
      chk(grant_valid, 1'b0);
      chk(irq, 1'b0);
      for (n = 0; n < 4; n++) begin
         m_ctl[n] = 32'h0;
         cc(n);
      end
      complete_run();
   end
endmodule // dcc_top_tb_top
